// *** spb_pkg.sv ***
/*
 * Shared constants and types for the serial pass-through bridge.
 * Assumes a single system clock; every other file imports this package.
 */
package spb_pkg;

    // System clock and serial framing
    localparam int unsigned CLK_HZ     = 250_000_000;
    localparam int unsigned BAUD_MAX   = 9600;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned DATA_BITS  = 8;
    localparam int unsigned CHANNELS   = 2;
    localparam int unsigned FIFO_DEPTH = 2;

    // Oversample tick positions within one bit time, and data bit indices within a byte
    localparam logic [3:0] TICK_MID   = 4'h7;
    localparam logic [3:0] TICK_LAST  = 4'hF;
    localparam logic [3:0] TICK_FIRST = 4'h0;
    localparam logic [2:0] BIT_FIRST  = 3'h0;
    localparam logic [2:0] BIT_LAST   = 3'h7;

    // Line levels at the host-side logic pins
    localparam logic LINE_IDLE  = 1'b1;
    localparam logic LINE_START = 1'b0;

    // Route and polarity selections
    localparam logic ROUTE_PROG   = 1'b0;
    localparam logic ROUTE_EXTRA  = 1'b1;
    localparam logic POL_INVERTED = 1'b0;
    localparam logic POL_TRUE     = 1'b1;

    // Channel indices
    localparam int unsigned CH_TO_TARGET = 0;
    localparam int unsigned CH_TO_HOST   = 1;

    typedef enum logic [1:0] {
        SPB_IDLE  = 2'b00,
        SPB_START = 2'b01,
        SPB_DATA  = 2'b10,
        SPB_STOP  = 2'b11
    } spb_bit_state_type;

    // Oversample divider; rounds down so sampling never runs slow
    function automatic int unsigned spb_divider(input int unsigned clk_hz,
                                                input int unsigned baud);
        return clk_hz / (baud * OVERSAMPLE);
    endfunction

endpackage

// *** spb_fifo2.sv ***
/*
 * Small valid/ready word buffer, two entries by default.
 * Assumes both sides share clk_sys; ce low freezes all state.
 */
`timescale 1ns/100ps
module spb_fifo2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = spb_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import spb_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("spb_fifo2: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + PW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

endmodule

// *** spb_bridge.sv ***
/*
 * Serial pass-through bridge between the host UART pins and a target chip.
 * Assumes host pins sit behind a level converter (idle high, TTL sense),
 * all inputs synchronous to clk_sys, and the target wired as configured.
 */
// What this block does
// - Relays bytes both ways, up to 9600 baud.
// - Route over programming lines or extra lines.
// - Selectable inverted or true target polarity.
// - Inverted mode: target idles like TTL UART.
// - Host side handled by own hardware UART.
// - Clock line driven out on programming route; data line only sampled.
`timescale 1ns/100ps
module spb_bridge #(
    parameter int unsigned CLK_HZ = spb_pkg::CLK_HZ,
    parameter int unsigned BAUD   = spb_pkg::BAUD_MAX
) (
    // Clock, reset, enable
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic ce,
    // Configuration
    input  wire logic route_sel,
    input  wire logic pol_sel,
    // Host UART pins
    input  wire logic host_uart_rx_pin,
    output logic      host_uart_tx_pin,
    // Programming lines
    output logic      prog_clock_line_o,
    output logic      prog_clock_line_oe,
    input  wire logic prog_data_line_i,
    output logic      prog_data_line_o,
    output logic      prog_data_line_oe,
    // Dedicated target UART lines
    output logic      target_uart_rx_line,
    input  wire logic target_uart_tx_line,
    // Status
    output logic [spb_pkg::CHANNELS-1:0] overrun_q,
    output logic [spb_pkg::CHANNELS-1:0] framing_q
);
    import spb_pkg::*;

    localparam int unsigned DIV = spb_divider(CLK_HZ, BAUD);
    localparam int unsigned DW  = (DIV > 1) ? $clog2(DIV) : 1;

    if (BAUD == 0 || BAUD > BAUD_MAX || DIV < 1) begin : g_bad
        $error("spb_bridge: baud rate not served by this clock");
    end

    // Oversample tick shared by all receivers and transmitters
    logic [DW-1:0] div_q;
    logic          tick_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            if (div_q == DW'(DIV - 1)) begin
                div_q  <= '0;
                tick_q <= 1'b1;
            end else begin
                div_q  <= div_q + DW'(1);
                tick_q <= 1'b0;
            end
        end
    end

    // Input capture; target side brought to host sense before framing
    logic [CHANNELS-1:0] line_in_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_in_q <= {CHANNELS{LINE_IDLE}};
        end else if (ce) begin
            line_in_q[CH_TO_TARGET] <= host_uart_rx_pin;
            if (route_sel == ROUTE_PROG) begin
                line_in_q[CH_TO_HOST] <= prog_data_line_i ^ (pol_sel == POL_TRUE);
            end else begin
                line_in_q[CH_TO_HOST] <= target_uart_tx_line ^ (pol_sel == POL_TRUE);
            end
        end
    end

    logic [CHANNELS-1:0] tx_line_q;

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        spb_bit_state_type    rx_st_q;
        logic [3:0]           rx_tick_q;
        logic [2:0]           rx_bit_q;
        logic [DATA_BITS-1:0] rx_sh_q;
        logic                 rx_vld_q;
        logic                 buf_in_ready;
        logic                 buf_out_valid;
        logic [DATA_BITS-1:0] buf_out_data;
        spb_bit_state_type    tx_st_q;
        logic [3:0]           tx_tick_q;
        logic [2:0]           tx_bit_q;
        logic [DATA_BITS-1:0] tx_sh_q;
        logic                 line;

        assign line = line_in_q[c];

        // Receiver: start checked at mid bit, then one sample per bit
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                rx_st_q      <= SPB_IDLE;
                rx_tick_q    <= TICK_FIRST;
                rx_bit_q     <= BIT_FIRST;
                rx_sh_q      <= '0;
                rx_vld_q     <= 1'b0;
                overrun_q[c] <= 1'b0;
                framing_q[c] <= 1'b0;
            end else if (ce) begin
                rx_vld_q <= 1'b0;
                if (tick_q) begin
                    case (rx_st_q)
                        SPB_IDLE: begin
                            if (line == LINE_START) begin
                                rx_st_q   <= SPB_START;
                                rx_tick_q <= TICK_FIRST;
                            end
                        end
                        SPB_START: begin
                            if (rx_tick_q == TICK_MID) begin
                                rx_tick_q <= TICK_FIRST;
                                rx_bit_q  <= BIT_FIRST;
                                rx_st_q   <= (line == LINE_START) ? SPB_DATA : SPB_IDLE;
                            end else begin
                                rx_tick_q <= rx_tick_q + 4'h1;
                            end
                        end
                        SPB_DATA: begin
                            if (rx_tick_q == TICK_LAST) begin
                                rx_tick_q <= TICK_FIRST;
                                rx_sh_q   <= {line, rx_sh_q[DATA_BITS-1:1]};
                                if (rx_bit_q == BIT_LAST) begin
                                    rx_st_q <= SPB_STOP;
                                end else begin
                                    rx_bit_q <= rx_bit_q + 3'h1;
                                end
                            end else begin
                                rx_tick_q <= rx_tick_q + 4'h1;
                            end
                        end
                        SPB_STOP: begin
                            if (rx_tick_q == TICK_LAST) begin
                                rx_st_q <= SPB_IDLE;
                                if (line != LINE_IDLE) begin
                                    framing_q[c] <= 1'b1;
                                end else if (buf_in_ready) begin
                                    rx_vld_q <= 1'b1;
                                end else begin
                                    // Serial source cannot be stalled; byte dropped
                                    overrun_q[c] <= 1'b1;
                                end
                            end else begin
                                rx_tick_q <= rx_tick_q + 4'h1;
                            end
                        end
                        default: rx_st_q <= SPB_IDLE;
                    endcase
                end
            end
        end

        // Absorbs a slow drain so back-to-back bytes are not lost
        spb_fifo2 #(
            .WIDTH (DATA_BITS),
            .DEPTH (FIFO_DEPTH)
        ) u_buf (
            .clk_sys   (clk_sys),
            .arst_n    (arst_n),
            .ce        (ce),
            .in_valid  (rx_vld_q),
            .in_ready  (buf_in_ready),
            .in_data   (rx_sh_q),
            .out_valid (buf_out_valid),
            .out_ready (tx_st_q == SPB_IDLE && tick_q),
            .out_data  (buf_out_data)
        );

        // Transmitter: 8N1, LSB first, sixteen ticks per bit
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                tx_st_q      <= SPB_IDLE;
                tx_tick_q    <= TICK_FIRST;
                tx_bit_q     <= BIT_FIRST;
                tx_sh_q      <= '0;
                tx_line_q[c] <= LINE_IDLE;
            end else if (ce) begin
                case (tx_st_q)
                    SPB_IDLE: begin
                        // Start on a tick so the start bit is a full bit time
                        if (buf_out_valid && tick_q) begin
                            tx_sh_q      <= buf_out_data;
                            tx_st_q      <= SPB_START;
                            tx_tick_q    <= TICK_FIRST;
                            tx_line_q[c] <= LINE_START;
                        end
                    end
                    SPB_START: begin
                        if (tick_q) begin
                            if (tx_tick_q == TICK_LAST) begin
                                tx_tick_q    <= TICK_FIRST;
                                tx_bit_q     <= BIT_FIRST;
                                tx_line_q[c] <= tx_sh_q[0];
                                tx_st_q      <= SPB_DATA;
                            end else begin
                                tx_tick_q <= tx_tick_q + 4'h1;
                            end
                        end
                    end
                    SPB_DATA: begin
                        if (tick_q) begin
                            if (tx_tick_q == TICK_LAST) begin
                                tx_tick_q <= TICK_FIRST;
                                if (tx_bit_q == BIT_LAST) begin
                                    tx_line_q[c] <= LINE_IDLE;
                                    tx_st_q      <= SPB_STOP;
                                end else begin
                                    tx_bit_q     <= tx_bit_q + 3'h1;
                                    tx_sh_q      <= {1'b0, tx_sh_q[DATA_BITS-1:1]};
                                    tx_line_q[c] <= tx_sh_q[1];
                                end
                            end else begin
                                tx_tick_q <= tx_tick_q + 4'h1;
                            end
                        end
                    end
                    SPB_STOP: begin
                        if (tick_q) begin
                            if (tx_tick_q == TICK_LAST) begin
                                tx_st_q <= SPB_IDLE;
                            end else begin
                                tx_tick_q <= tx_tick_q + 4'h1;
                            end
                        end
                    end
                    default: tx_st_q <= SPB_IDLE;
                endcase
            end
        end
    end

    // Pin registers; unused target line parks at idle level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_uart_tx_pin    <= LINE_IDLE;
            prog_clock_line_o   <= LINE_IDLE;
            prog_clock_line_oe  <= 1'b0;
            prog_data_line_o    <= 1'b0;
            prog_data_line_oe   <= 1'b0;
            target_uart_rx_line <= LINE_IDLE;
        end else if (ce) begin
            host_uart_tx_pin  <= tx_line_q[CH_TO_HOST];
            prog_data_line_o  <= 1'b0;
            prog_data_line_oe <= 1'b0;
            if (route_sel == ROUTE_PROG) begin
                prog_clock_line_o   <= tx_line_q[CH_TO_TARGET] ^ (pol_sel == POL_TRUE);
                prog_clock_line_oe  <= 1'b1;
                target_uart_rx_line <= LINE_IDLE ^ (pol_sel == POL_TRUE);
            end else begin
                prog_clock_line_o   <= LINE_IDLE;
                prog_clock_line_oe  <= 1'b0;
                target_uart_rx_line <= tx_line_q[CH_TO_TARGET] ^ (pol_sel == POL_TRUE);
            end
        end
    end

endmodule

// *** spb_bridge_monitor.sv ***
/*
 * Checker of the bridge pins, bound into every spb_bridge instance.
 * Assumes route and polarity change only while the lines are idle.
 */
`timescale 1ns/100ps
module spb_bridge_monitor #(
    parameter int unsigned CLK_HZ = spb_pkg::CLK_HZ,
    parameter int unsigned BAUD   = spb_pkg::BAUD_MAX
) (
    // Clock, reset, enable
    input wire logic                         clk_sys,
    input wire logic                         arst_n,
    input wire logic                         ce,
    // Configuration and pins
    input wire logic                         route_sel,
    input wire logic                         pol_sel,
    input wire logic                         host_uart_rx_pin,
    input wire logic                         host_uart_tx_pin,
    input wire logic                         prog_clock_line_o,
    input wire logic                         prog_clock_line_oe,
    input wire logic                         prog_data_line_i,
    input wire logic                         prog_data_line_o,
    input wire logic                         prog_data_line_oe,
    input wire logic                         target_uart_rx_line,
    input wire logic                         target_uart_tx_line,
    // Status
    input wire logic [spb_pkg::CHANNELS-1:0] overrun_q,
    input wire logic [spb_pkg::CHANNELS-1:0] framing_q
);
    import spb_pkg::*;
    localparam int BIT_CYC = int'(CLK_HZ / (BAUD * OVERSAMPLE) * OVERSAMPLE);
    // Start bit may stretch by one tick, then eight zero bits
    localparam int MAX_LOW = BIT_CYC * 9 + BIT_CYC / 16;
    logic host_prev_q;
    int   host_run_q;
    logic live_q;
    // Length of the previous level, valid at each edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_prev_q <= LINE_IDLE;
            host_run_q  <= 0;
            live_q      <= 1'b0;
        end else begin
            live_q      <= 1'b1;
            host_prev_q <= host_uart_tx_pin;
            host_run_q  <= (host_uart_tx_pin != host_prev_q) ? 1 : host_run_q + 1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    // Release edge skipped: pins still show reset values one edge later
    default disable iff (!arst_n || !live_q);
    sequence s_host_edge;
        host_uart_tx_pin != host_prev_q;
    endsequence
    sequence s_host_rise;
        host_uart_tx_pin && !host_prev_q;
    endsequence
    a_clock_driven: assert property (
        ce && route_sel == ROUTE_PROG |=> prog_clock_line_oe)
        else $error("clock line not driven on programming route");
    a_clock_released: assert property (
        ce && route_sel == ROUTE_EXTRA |=> !prog_clock_line_oe)
        else $error("clock line still driven on dedicated route");
    a_data_undriven: assert property (
        !prog_data_line_oe && !prog_data_line_o)
        else $error("data line driven");
    a_parked_idle: assert property (
        ce && route_sel == ROUTE_PROG |=> target_uart_rx_line == (LINE_IDLE ^ $past(pol_sel)))
        else $error("unused target line not at idle level");
    a_host_bit_width: assert property (
        s_host_edge |-> host_run_q >= BIT_CYC)
        else $error("host output level shorter than one bit");
    a_host_low_bound: assert property (
        s_host_rise |-> host_run_q <= MAX_LOW)
        else $error("host output low longer than a frame allows");
    a_flags_sticky: assert property (
        1'b1 |=> (framing_q & $past(framing_q)) == $past(framing_q)
                 && (overrun_q & $past(overrun_q)) == $past(overrun_q))
        else $error("status flag cleared without reset");
    a_frozen_hold: assert property (
        !ce |=> $stable(host_uart_tx_pin) && $stable(target_uart_rx_line))
        else $error("output moved while frozen");
endmodule

bind spb_bridge spb_bridge_monitor #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) spb_bridge_monitor_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .route_sel(route_sel), .pol_sel(pol_sel),
    .host_uart_rx_pin(host_uart_rx_pin), .host_uart_tx_pin(host_uart_tx_pin),
    .prog_clock_line_o(prog_clock_line_o), .prog_clock_line_oe(prog_clock_line_oe),
    .prog_data_line_i(prog_data_line_i), .prog_data_line_o(prog_data_line_o),
    .prog_data_line_oe(prog_data_line_oe), .target_uart_rx_line(target_uart_rx_line),
    .target_uart_tx_line(target_uart_tx_line), .overrun_q(overrun_q), .framing_q(framing_q));

// *** spb_target_model.sv ***
/*
 * Target chip model: bit-banged UART on whichever lines are routed.
 * Assumes the bench holds route and polarity steady during frames.
 */
`timescale 1ns/100ps
module spb_target_model #(
    parameter int BIT = 160
) (
    // Clock and selections
    input wire logic clk_sys,
    input wire logic route_sel,
    input wire logic pol_sel,
    // Bridge toward target
    input wire logic prog_clock_line_o,
    input wire logic target_uart_rx_line,
    // Target toward bridge
    output logic     prog_data_line_i,
    output logic     target_uart_tx_line
);
    import spb_pkg::*;
    logic       tx_q = LINE_IDLE;
    logic       noise_q = 1'b0;
    logic       rx_in;
    logic [7:0] rx_byte;
    logic [7:0] rx_q[$];
    // Unselected line toggles so a wrong route cannot pass by luck
    always @(posedge clk_sys) begin
        noise_q <= ~noise_q;
    end
    assign prog_data_line_i    = route_sel == ROUTE_PROG ? tx_q ^ pol_sel : noise_q;
    assign target_uart_tx_line = route_sel == ROUTE_EXTRA ? tx_q ^ pol_sel : noise_q;
    assign rx_in = (route_sel == ROUTE_PROG ? prog_clock_line_o : target_uart_rx_line) ^ pol_sel;
    task automatic send(input logic [7:0] b, input logic good);
        logic [9:0] f;
        f = {good, b, LINE_START};
        for (int i = 0; i < 10; i++) begin
            tx_q <= f[i];
            repeat ((i == 9 && !good) ? BIT * 3 / 4 : BIT) @(posedge clk_sys);
        end
        tx_q <= LINE_IDLE;
    endtask
    // Software receiver; a short glitch is dropped at mid start bit
    always begin
        @(posedge clk_sys);
        if (rx_in === LINE_START) begin
            repeat (BIT / 2) @(posedge clk_sys);
            if (rx_in === LINE_START) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    rx_byte[i] = rx_in;
                end
                repeat (BIT) @(posedge clk_sys);
                if (rx_in === LINE_IDLE) begin
                    rx_q.push_back(rx_byte);
                end
            end
        end
    end
endmodule

// *** tb_top.sv ***
/*
 * Self-checking bench: host pins driven here, target model at far side.
 * Assumes package, design, model and checker are compiled first.
 */
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
    import spb_pkg::*;
    // Ten clocks per tick keeps a frame at 1600 cycles
    localparam int unsigned SIM_HZ = 1_536_000;
    localparam int          BIT    = int'(SIM_HZ / (BAUD_MAX * OVERSAMPLE) * OVERSAMPLE);
    logic                clk_sys, arst_n, ce, route_sel, pol_sel;
    logic                host_uart_rx_pin, host_uart_tx_pin, target_uart_rx_line;
    logic                prog_clock_line_o, prog_clock_line_oe, prog_data_line_i;
    logic                prog_data_line_o, prog_data_line_oe, target_uart_tx_line;
    logic [CHANNELS-1:0] overrun_q, framing_q;
    logic [7:0]          pat [4] = '{8'hA5, 8'h01, 8'h80, 8'h3C};
    int                  err_total = 0;
    int                  n_tests = 0;
    spb_bridge #(.CLK_HZ(SIM_HZ), .BAUD(BAUD_MAX)) spb_bridge_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .route_sel(route_sel), .pol_sel(pol_sel),
        .host_uart_rx_pin(host_uart_rx_pin), .host_uart_tx_pin(host_uart_tx_pin),
        .prog_clock_line_o(prog_clock_line_o), .prog_clock_line_oe(prog_clock_line_oe),
        .prog_data_line_i(prog_data_line_i), .prog_data_line_o(prog_data_line_o),
        .prog_data_line_oe(prog_data_line_oe), .target_uart_rx_line(target_uart_rx_line),
        .target_uart_tx_line(target_uart_tx_line), .overrun_q(overrun_q), .framing_q(framing_q));
    spb_target_model #(.BIT(BIT)) spb_target_model_i (
        .clk_sys(clk_sys), .route_sel(route_sel), .pol_sel(pol_sel),
        .prog_clock_line_o(prog_clock_line_o), .target_uart_rx_line(target_uart_rx_line),
        .prog_data_line_i(prog_data_line_i), .target_uart_tx_line(target_uart_tx_line));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic host_send(input logic [7:0] b, input logic good);
        logic [9:0] f;
        f = {good, b, LINE_START};
        for (int i = 0; i < 10; i++) begin
            host_uart_rx_pin <= f[i];
            repeat ((i == 9 && !good) ? BIT * 3 / 4 : BIT) @(posedge clk_sys);
        end
        // A good stop bit is already idle; next frame may start here
        if (!good) begin
            host_uart_rx_pin <= LINE_IDLE;
        end
    endtask
    task automatic host_get(output logic [7:0] b);
        int t;
        for (t = 0; t < 30 * BIT && host_uart_tx_pin !== LINE_START; t++) @(posedge clk_sys);
        if (t >= 30 * BIT) begin
            err_total++;
            end_of_test();
        end
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_sys);
            b[i] = host_uart_tx_pin;
        end
        repeat (BIT) @(posedge clk_sys);
        `CHECK("host stop bit", LINE_IDLE, host_uart_tx_pin)
    endtask
    task automatic wait_target(input int n);
        int t;
        for (t = 0; t < 30 * BIT && spb_target_model_i.rx_q.size() <= n; t++) @(posedge clk_sys);
        if (t >= 30 * BIT) begin
            err_total++;
            end_of_test();
        end
    endtask
    // Settle both sides before and after a change; mid-frame changes corrupt
    task automatic set_cfg(input logic r, input logic p);
        repeat (2 * BIT) @(posedge clk_sys);
        route_sel <= r;
        pol_sel   <= p;
        repeat (2 * BIT) @(posedge clk_sys);
    endtask
    task automatic t_to_target(input logic r, input logic p, input logic [7:0] b);
        int n;
        set_cfg(r, p);
        n = spb_target_model_i.rx_q.size();
        `CHECK("target idle", LINE_IDLE ^ p, r ? target_uart_rx_line : prog_clock_line_o)
        `CHECK("clock line enable", r == ROUTE_PROG, prog_clock_line_oe)
        host_send(b, 1'b1);
        wait_target(n);
        `CHECK("byte to target", b, spb_target_model_i.rx_q[n])
    endtask
    task automatic t_to_host(input logic r, input logic p, input logic [7:0] b);
        logic [7:0] got;
        set_cfg(r, p);
        fork
            spb_target_model_i.send(b, 1'b1);
            host_get(got);
        join
        `CHECK("byte to host", b, got)
    endtask
    task automatic t_back_to_back();
        int n;
        set_cfg(ROUTE_EXTRA, POL_INVERTED);
        n = spb_target_model_i.rx_q.size();
        host_send(8'h00, 1'b1);
        host_send(8'hFF, 1'b1);
        wait_target(n + 1);
        `CHECK("first byte", 8'h00, spb_target_model_i.rx_q[n])
        `CHECK("second byte", 8'hFF, spb_target_model_i.rx_q[n + 1])
    endtask
    task automatic t_framing();
        int n;
        n = spb_target_model_i.rx_q.size();
        host_send(8'h5A, 1'b0);
        repeat (4 * BIT) @(posedge clk_sys);
        `CHECK("host framing flag", 1'b1, framing_q[CH_TO_TARGET])
        `CHECK("dropped byte", n, spb_target_model_i.rx_q.size())
        spb_target_model_i.send(8'h5A, 1'b0);
        repeat (4 * BIT) @(posedge clk_sys);
        `CHECK("target framing flag", 1'b1, framing_q[CH_TO_HOST])
        `CHECK("host line idle", LINE_IDLE, host_uart_tx_pin)
        `CHECK("no overrun", 2'h0, overrun_q)
    endtask
    initial begin
        arst_n           = 1'b0;
        ce               = 1'b1;
        route_sel        = ROUTE_PROG;
        pol_sel          = POL_INVERTED;
        host_uart_rx_pin = LINE_IDLE;
        repeat (6) @(posedge clk_sys);
        `CHECK("host line in reset", LINE_IDLE, host_uart_tx_pin)
        `CHECK("clock enable in reset", 1'b0, prog_clock_line_oe)
        `CHECK("target line in reset", LINE_IDLE, target_uart_rx_line)
        arst_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            t_to_target(k[1], k[0], pat[k]);
            t_to_host(k[1], k[0], ~pat[k]);
        end
        t_back_to_back();
        ce <= 1'b0;
        repeat (8) @(posedge clk_sys);
        ce <= 1'b1;
        // Inverted polarity left selected for normal use
        set_cfg(ROUTE_PROG, POL_INVERTED);
        t_framing();
        end_of_test();
    end
endmodule
